// >>> logic/rxsc_map.svh
// Register indices, field positions, reset values and timing counts for the rx signaling bank
`ifndef RXSC_MAP_SVH
`define RXSC_MAP_SVH

`define RXSC_NPORTS 8
`define RXSC_NSIG 16
// Register index within one port block; byte address is four times the full index
`define RXSC_PORT_STRIDE 12'h200
`define RXSC_IDX_MW1 9'h03c
`define RXSC_IDX_MW2 9'h03d
`define RXSC_IDX_MW3 9'h03e
`define RXSC_IDX_SIG_FIRST 9'h040
`define RXSC_IDX_SIG_LAST 9'h04f
`define RXSC_IDX_LCV_HI 9'h050
`define RXSC_IDX_LCV_LO 9'h051
`define RXSC_IDX_PCV_HI 9'h052
`define RXSC_IDX_PCV_LO 9'h053
`define RXSC_IDX_FOS_HI 9'h054
`define RXSC_IDX_FOS_LO 9'h055
`define RXSC_IDX_EB_HI 9'h056
`define RXSC_IDX_EB_LO 9'h057
`define RXSC_IDX_CFG 9'h0f0
`define RXSC_IDX_INT_STAT 9'h0f1
`define RXSC_IDX_INT_MASK 9'h0f2

// Configuration register fields
`define RXSC_CFG_E1_BIT 0
`define RXSC_CFG_ESF_BIT 1
`define RXSC_CFG_RESET 8'h00
`define RXSC_CFG_WMASK 8'h03

// Interrupt status and mask fields
`define RXSC_INT_SYNC_LOSS_BIT 0
`define RXSC_INT_SIG_CHANGE_BIT 1
`define RXSC_INT_CNT_SAT_BIT 2
`define RXSC_INT_WIDTH 3

`define RXSC_BYTE_RESET 8'h00
`define RXSC_CNT_RESET 16'h0000
`define RXSC_CNT_MAX 16'hffff

// Channel ranges
`define RXSC_T1_HALF 5'd12
`define RXSC_T1_LAST 5'd24
`define RXSC_E1_HALF 5'd15
`define RXSC_E1_LAST 5'd30

// Digital milliwatt sequence, one byte per frame, repeating
`define RXSC_MW_B0 8'h1e
`define RXSC_MW_B1 8'h0b
`define RXSC_MW_B2 8'h0b
`define RXSC_MW_B3 8'h1e
`define RXSC_MW_B4 8'h9e
`define RXSC_MW_B5 8'h8b
`define RXSC_MW_B6 8'h8b
`define RXSC_MW_B7 8'h9e

// Host polling intervals for signaling, in microseconds and cycles
`define RXSC_CLK_NS 10
`define RXSC_D4_POLL_US 1500
`define RXSC_ESF_POLL_US 3000
`define RXSC_D4_POLL_CYC ((`RXSC_D4_POLL_US * 1000) / `RXSC_CLK_NS)
`define RXSC_ESF_POLL_CYC ((`RXSC_ESF_POLL_US * 1000) / `RXSC_CLK_NS)

`endif

// >>> logic/rxsc_pkg.sv
// Types and shared functions of the rx signaling and error counter bank
`default_nettype none
`include "rxsc_map.svh"
package rxsc_pkg;
  typedef logic [7:0] rxsc_byte_t;
  typedef logic [15:0] rxsc_cnt_t;
  typedef logic [4:0] rxsc_chan_t;
  typedef logic [3:0] rxsc_nib_t;
  typedef logic [`RXSC_NSIG-1:0][7:0] rxsc_sig_bank_t;

  // Milliwatt byte for a frame phase
  function automatic rxsc_byte_t rxsc_mw_byte(input logic [2:0] phase);
    unique case (phase)
      3'd0: rxsc_mw_byte = `RXSC_MW_B0;
      3'd1: rxsc_mw_byte = `RXSC_MW_B1;
      3'd2: rxsc_mw_byte = `RXSC_MW_B2;
      3'd3: rxsc_mw_byte = `RXSC_MW_B3;
      3'd4: rxsc_mw_byte = `RXSC_MW_B4;
      3'd5: rxsc_mw_byte = `RXSC_MW_B5;
      3'd6: rxsc_mw_byte = `RXSC_MW_B6;
      3'd7: rxsc_mw_byte = `RXSC_MW_B7;
    endcase
  endfunction : rxsc_mw_byte

  // Saturating increment, shared by all four counters
  function automatic rxsc_cnt_t rxsc_bump(input rxsc_cnt_t c, input logic ev);
    if (ev && c != `RXSC_CNT_MAX) begin
      rxsc_bump = c + 16'h0001;
    end else begin
      rxsc_bump = c;
    end
  endfunction : rxsc_bump
endpackage : rxsc_pkg
`default_nettype wire

// >>> logic/rxsc_port_if.sv
// Per-port bundle between the top and its signaling and counter modules
`default_nettype none
interface rxsc_port_if;
  import rxsc_pkg::*;
  logic e1;
  logic esf;
  logic sync_loss;
  logic sig_valid;
  rxsc_chan_t sig_chan;
  rxsc_nib_t sig_abcd;
  logic lcv_ev;
  logic pcv_ev;
  logic fos_ev;
  logic eb_ev;
  rxsc_sig_bank_t sig_regs;
  logic sig_changed;
  rxsc_cnt_t lcv;
  rxsc_cnt_t pcv;
  rxsc_cnt_t frames_unsynced_count;
  rxsc_cnt_t eb;
  logic sat;

  modport sig_mp (
    input e1, esf, sync_loss, sig_valid, sig_chan, sig_abcd,
    output sig_regs, sig_changed
  );
  modport cnt_mp (
    input e1, lcv_ev, pcv_ev, fos_ev, eb_ev,
    output lcv, pcv, frames_unsynced_count, eb, sat
  );
  modport top_mp (
    output e1, esf, sync_loss, sig_valid, sig_chan, sig_abcd, lcv_ev, pcv_ev, fos_ev, eb_ev,
    input sig_regs, sig_changed, lcv, pcv, frames_unsynced_count, eb, sat
  );
endinterface : rxsc_port_if
`default_nettype wire

// >>> logic/rxsc_sig_store.sv
// Receive signaling capture for one port: sixteen bytes of A/B/C/D nibbles
`default_nettype none
`include "rxsc_map.svh"
module rxsc_sig_store (
  input wire logic pclk,
  input wire logic presetn,
  rxsc_port_if.sig_mp bus
);
  import rxsc_pkg::*;

  rxsc_sig_bank_t sig_r;
  logic hit;
  logic hi_half;
  logic [3:0] slot;
  rxsc_nib_t nib;
  rxsc_byte_t old_byte;
  rxsc_byte_t new_byte;

  // Channel to register slot and nibble half
  always_comb begin
    hit = 1'b0;
    hi_half = 1'b0;
    slot = 4'h0;
    if (bus.e1) begin
      if (bus.sig_chan == 5'd0) begin
        hit = 1'b1; // Spare/alarm bits land in the low nibble of the first register
      end else if (bus.sig_chan <= `RXSC_E1_HALF) begin
        hit = 1'b1;
        hi_half = 1'b1;
        slot = bus.sig_chan[3:0];
      end else if (bus.sig_chan <= `RXSC_E1_LAST) begin
        hit = 1'b1;
        slot = 4'(bus.sig_chan - `RXSC_E1_HALF);
      end
    end else begin
      if (bus.sig_chan >= 5'd1 && bus.sig_chan <= `RXSC_T1_HALF) begin
        hit = 1'b1;
        hi_half = 1'b1;
        slot = 4'(bus.sig_chan - 5'd1);
      end else if (bus.sig_chan > `RXSC_T1_HALF && bus.sig_chan <= `RXSC_T1_LAST) begin
        hit = 1'b1;
        slot = 4'(bus.sig_chan - 5'd13);
      end
    end
  end

  // D4 carries only A and B, so they are repeated into C and D
  always_comb begin
    if (!bus.e1 && !bus.esf) begin
      nib = {bus.sig_abcd[3], bus.sig_abcd[2], bus.sig_abcd[3], bus.sig_abcd[2]};
    end else begin
      nib = bus.sig_abcd; // All four bits kept in ESF and E1
    end
    old_byte = sig_r[slot];
    new_byte = hi_half ? {nib, old_byte[3:0]} : {old_byte[7:4], nib};
    // A T1 capture left before a mode switch must not show through in E1
    if (bus.e1 && bus.sig_chan == 5'd0) begin
      new_byte = {4'h0, nib};
    end
  end

  // Store frozen while frame sync is lost, keeping the last good values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_r <= '0;
    end else if (bus.sig_valid && hit && !bus.sync_loss) begin
      sig_r[slot] <= new_byte;
    end
  end

  // One-cycle pulse when a stored byte really changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.sig_changed <= 1'b0;
    end else begin
      bus.sig_changed <= bus.sig_valid && hit && !bus.sync_loss && (new_byte != old_byte);
    end
  end

  assign bus.sig_regs = sig_r;
endmodule : rxsc_sig_store
`default_nettype wire

// >>> logic/rxsc_err_count.sv
// Four 16-bit receive error counters for one port
`default_nettype none
`include "rxsc_map.svh"
module rxsc_err_count (
  input wire logic pclk,
  input wire logic presetn,
  rxsc_port_if.cnt_mp bus
);
  import rxsc_pkg::*;

  rxsc_cnt_t lcv_r;
  rxsc_cnt_t pcv_r;
  rxsc_cnt_t fos_r;
  rxsc_cnt_t eb_r;
  logic eb_qual;

  // E-bit errors only mean something on an E1 line
  assign eb_qual = bus.eb_ev && bus.e1;

  // Counters saturate rather than wrap so a large count is never mistaken for a small one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcv_r <= `RXSC_CNT_RESET;
      pcv_r <= `RXSC_CNT_RESET;
      fos_r <= `RXSC_CNT_RESET;
      eb_r <= `RXSC_CNT_RESET;
    end else begin
      lcv_r <= rxsc_bump(lcv_r, bus.lcv_ev);
      pcv_r <= rxsc_bump(pcv_r, bus.pcv_ev);
      fos_r <= rxsc_bump(fos_r, bus.fos_ev);
      eb_r <= rxsc_bump(eb_r, eb_qual);
    end
  end

  // Pulse when a counter reaches its ceiling on this event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.sat <= 1'b0;
    end else begin
      bus.sat <= (bus.lcv_ev && lcv_r == 16'hfffe) || (bus.pcv_ev && pcv_r == 16'hfffe) ||
                 (bus.fos_ev && fos_r == 16'hfffe) || (eb_qual && eb_r == 16'hfffe);
    end
  end

  assign bus.lcv = lcv_r;
  assign bus.pcv = pcv_r;
  assign bus.frames_unsynced_count = fos_r;
  assign bus.eb = eb_r;
endmodule : rxsc_err_count
`default_nettype wire

// >>> logic/rxsc_top.sv
// Eight-port receive signaling, milliwatt and error counter bank behind APB
`default_nettype none
`include "rxsc_map.svh"
module rxsc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [7:0] rx_frame_start,
  input wire logic [7:0] rx_ts_valid,
  input wire logic [7:0][4:0] rx_ts_chan,
  input wire logic [7:0][7:0] rx_ts_data,
  output logic [7:0] rx_out_valid,
  output logic [7:0][4:0] rx_out_chan,
  output logic [7:0][7:0] rx_out_data,
  input wire logic [7:0] sig_valid,
  input wire logic [7:0][4:0] sig_chan,
  input wire logic [7:0][3:0] sig_abcd,
  input wire logic [7:0] frame_sync_loss,
  input wire logic [7:0] lcv_event,
  input wire logic [7:0] pcv_event,
  input wire logic [7:0] fos_event,
  input wire logic [7:0] ebit_event
);
  import rxsc_pkg::*;

  localparam int NP = `RXSC_NPORTS;

  // Software-visible control state
  logic [NP-1:0][23:0] channel_enable_bits_r;
  logic [NP-1:0][7:0] cfg_r;
  logic [NP-1:0][`RXSC_INT_WIDTH-1:0] int_stat_r;
  logic [NP-1:0][`RXSC_INT_WIDTH-1:0] int_mask_r;
  logic [NP-1:0][`RXSC_INT_WIDTH-1:0] int_set;
  logic [NP-1:0] sync_loss_d_r;
  logic [NP-1:0][2:0] mw_phase_r;

  // Bus-side state
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic [7:0] rx_out_valid_r;
  logic [7:0][4:0] rx_out_chan_r;
  logic [7:0][7:0] rx_out_data_r;

  // Copies of per-port results, so the read mux can index them
  rxsc_sig_bank_t [NP-1:0] sig_all;
  rxsc_cnt_t [NP-1:0] lcv_all;
  rxsc_cnt_t [NP-1:0] pcv_all;
  rxsc_cnt_t [NP-1:0] fos_all;
  rxsc_cnt_t [NP-1:0] eb_all;
  logic [NP-1:0] sig_chg_all;
  logic [NP-1:0] sat_all;

  // Address decode
  logic [11:0] idx;
  logic [2:0] port_sel;
  logic [8:0] reg_sel;
  logic acc_read;
  logic acc_write;
  logic addr_ok;
  logic misaligned;
  rxsc_byte_t rd_byte;
  rxsc_byte_t wr_byte;

  assign idx = paddr[13:2];
  assign port_sel = idx[11:9]; // Port block = index / 0x200
  assign reg_sel = idx[8:0];
  assign misaligned = (paddr[1:0] != 2'b00);
  assign wr_byte = pwdata[7:0];

  // Reply is prepared in the first access cycle, write commits when pready is seen
  assign acc_read = psel && penable && !pready_r;
  assign acc_write = psel && penable && pready_r && pwrite && !pslverr_r;

  // Per-port submodules, joined through the bundle
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_port
      rxsc_port_if pif ();
      assign pif.e1 = cfg_r[g][`RXSC_CFG_E1_BIT];
      assign pif.esf = cfg_r[g][`RXSC_CFG_ESF_BIT];
      assign pif.sync_loss = frame_sync_loss[g];
      assign pif.sig_valid = sig_valid[g];
      assign pif.sig_chan = sig_chan[g];
      assign pif.sig_abcd = sig_abcd[g];
      assign pif.lcv_ev = lcv_event[g];
      assign pif.pcv_ev = pcv_event[g];
      assign pif.fos_ev = fos_event[g];
      assign pif.eb_ev = ebit_event[g];
      assign sig_all[g] = pif.sig_regs;
      assign sig_chg_all[g] = pif.sig_changed;
      assign lcv_all[g] = pif.lcv;
      assign pcv_all[g] = pif.pcv;
      assign fos_all[g] = pif.frames_unsynced_count;
      assign eb_all[g] = pif.eb;
      assign sat_all[g] = pif.sat;

      rxsc_sig_store u_sig (
        .pclk(pclk),
        .presetn(presetn),
        .bus(pif)
      );

      rxsc_err_count u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .bus(pif)
      );
    end
  endgenerate

  // Which indices exist in a port block
  always_comb begin
    unique case (reg_sel)
      `RXSC_IDX_MW1, `RXSC_IDX_MW2, `RXSC_IDX_MW3,
      `RXSC_IDX_LCV_HI, `RXSC_IDX_LCV_LO, `RXSC_IDX_PCV_HI, `RXSC_IDX_PCV_LO,
      `RXSC_IDX_FOS_HI, `RXSC_IDX_FOS_LO, `RXSC_IDX_EB_HI, `RXSC_IDX_EB_LO,
      `RXSC_IDX_CFG, `RXSC_IDX_INT_STAT, `RXSC_IDX_INT_MASK: addr_ok = !misaligned;
      default: addr_ok = !misaligned && reg_sel >= `RXSC_IDX_SIG_FIRST &&
                         reg_sel <= `RXSC_IDX_SIG_LAST;
    endcase
  end

  // Read mux; pure selection, so reading never disturbs stored values
  always_comb begin
    rd_byte = `RXSC_BYTE_RESET;
    unique case (reg_sel)
      `RXSC_IDX_MW1: rd_byte = channel_enable_bits_r[port_sel][7:0];
      `RXSC_IDX_MW2: rd_byte = channel_enable_bits_r[port_sel][15:8];
      `RXSC_IDX_MW3: rd_byte = channel_enable_bits_r[port_sel][23:16];
      `RXSC_IDX_LCV_HI: rd_byte = lcv_all[port_sel][15:8];
      `RXSC_IDX_LCV_LO: rd_byte = lcv_all[port_sel][7:0];
      `RXSC_IDX_PCV_HI: rd_byte = pcv_all[port_sel][15:8];
      `RXSC_IDX_PCV_LO: rd_byte = pcv_all[port_sel][7:0];
      `RXSC_IDX_FOS_HI: rd_byte = fos_all[port_sel][15:8];
      `RXSC_IDX_FOS_LO: rd_byte = fos_all[port_sel][7:0];
      `RXSC_IDX_EB_HI: rd_byte = eb_all[port_sel][15:8];
      `RXSC_IDX_EB_LO: rd_byte = eb_all[port_sel][7:0];
      `RXSC_IDX_CFG: rd_byte = cfg_r[port_sel];
      `RXSC_IDX_INT_STAT: rd_byte = {5'h00, int_stat_r[port_sel]};
      `RXSC_IDX_INT_MASK: rd_byte = {5'h00, int_mask_r[port_sel]};
      default: begin
        if (reg_sel >= `RXSC_IDX_SIG_FIRST && reg_sel <= `RXSC_IDX_SIG_LAST) begin
          rd_byte = sig_all[port_sel][reg_sel[3:0]];
        end
      end
    endcase
  end

  // APB answer: pready one cycle after the access phase begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc_read;
      if (acc_read) begin
        pslverr_r <= !addr_ok;
        prdata_r <= (!pwrite && addr_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // Milliwatt enables and configuration; signaling and counter indices accept no write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_bits_r <= '0;
      cfg_r <= '0;
    end else if (acc_write) begin
      unique case (reg_sel)
        `RXSC_IDX_MW1: channel_enable_bits_r[port_sel][7:0] <= wr_byte;
        `RXSC_IDX_MW2: channel_enable_bits_r[port_sel][15:8] <= wr_byte;
        `RXSC_IDX_MW3: channel_enable_bits_r[port_sel][23:16] <= wr_byte;
        `RXSC_IDX_CFG: cfg_r[port_sel] <= wr_byte & `RXSC_CFG_WMASK;
        default: ;
      endcase
    end
  end

  // Interrupt events per port
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      int_set[p][`RXSC_INT_SYNC_LOSS_BIT] = frame_sync_loss[p] && !sync_loss_d_r[p];
      int_set[p][`RXSC_INT_SIG_CHANGE_BIT] = sig_chg_all[p];
      int_set[p][`RXSC_INT_CNT_SAT_BIT] = sat_all[p];
    end
  end

  // Sticky status, write one to clear; a new event in the clear cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= '0;
      int_mask_r <= '0;
      sync_loss_d_r <= '0;
    end else begin
      sync_loss_d_r <= frame_sync_loss;
      for (int p = 0; p < NP; p++) begin
        if (acc_write && port_sel == 3'(p) && reg_sel == `RXSC_IDX_INT_STAT) begin
          int_stat_r[p] <= (int_stat_r[p] & ~wr_byte[2:0]) | int_set[p];
        end else begin
          int_stat_r[p] <= int_stat_r[p] | int_set[p];
        end
        if (acc_write && port_sel == 3'(p) && reg_sel == `RXSC_IDX_INT_MASK) begin
          int_mask_r[p] <= wr_byte[2:0];
        end
      end
    end
  end

  // One level interrupt for all ports, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  // Frame phase of the milliwatt sequence; restarts only by wrapping, one step per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mw_phase_r <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (rx_frame_start[p]) begin
          mw_phase_r[p] <= mw_phase_r[p] + 3'd1;
        end
      end
    end
  end

  // Receive data path, one stage; channels outside 1-24 are never substituted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_out_valid_r <= '0;
      rx_out_chan_r <= '0;
      rx_out_data_r <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        rx_out_valid_r[p] <= rx_ts_valid[p];
        rx_out_chan_r[p] <= rx_ts_chan[p];
        if (rx_ts_chan[p] >= 5'd1 && rx_ts_chan[p] <= `RXSC_T1_LAST &&
            channel_enable_bits_r[p][5'(rx_ts_chan[p] - 5'd1)]) begin
          rx_out_data_r[p] <= rxsc_mw_byte(mw_phase_r[p]);
        end else begin
          rx_out_data_r[p] <= rx_ts_data[p];
        end
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign rx_out_valid = rx_out_valid_r;
  assign rx_out_chan = rx_out_chan_r;
  assign rx_out_data = rx_out_data_r;
endmodule : rxsc_top
`default_nettype wire

// >>> verif/rxsc_line_model.sv
// Line-side stand-in: drives received timeslots, signaling strobes and error events
`default_nettype none
module rxsc_line_model (
  input wire logic pclk,
  output logic [7:0] rx_frame_start,
  output logic [7:0] rx_ts_valid,
  output logic [7:0][4:0] rx_ts_chan,
  output logic [7:0][7:0] rx_ts_data,
  output logic [7:0] sig_valid,
  output logic [7:0][4:0] sig_chan,
  output logic [7:0][3:0] sig_abcd,
  output logic [7:0] frame_sync_loss,
  output logic [7:0] lcv_event,
  output logic [7:0] pcv_event,
  output logic [7:0] fos_event,
  output logic [7:0] ebit_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet line at time zero
  initial begin
    {rx_frame_start, rx_ts_valid, rx_ts_chan, rx_ts_data} = '0;
    {sig_valid, sig_chan, sig_abcd, frame_sync_loss} = '0;
    {lcv_event, pcv_event, fos_event, ebit_event} = '0;
  end
  // One timeslot; data inverted afterwards so a stale byte never matches
  task automatic ts(input int p, input logic [4:0] c, input logic [7:0] d);
    @(posedge pclk);
    rx_ts_valid[p] <= 1'b1;
    rx_ts_chan[p] <= c;
    rx_ts_data[p] <= d;
    @(posedge pclk);
    rx_ts_valid[p] <= 1'b0;
    rx_ts_data[p] <= ~d;
  endtask : ts
  // One signaling capture strobe, nibble A in bit 3
  task automatic sig(input int p, input logic [4:0] c, input logic [3:0] s);
    @(posedge pclk);
    sig_valid[p] <= 1'b1;
    sig_chan[p] <= c;
    sig_abcd[p] <= s;
    @(posedge pclk);
    sig_valid[p] <= 1'b0;
    sig_abcd[p] <= ~s;
  endtask : sig
  // Back-to-back event pulses, mask order line, path, frame, E-bit
  task automatic ev(input int p, input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge pclk);
      {lcv_event[p], pcv_event[p], fos_event[p], ebit_event[p]} <= m;
    end
    @(posedge pclk);
    {lcv_event[p], pcv_event[p], fos_event[p], ebit_event[p]} <= 4'h0;
  endtask : ev
  // Frame boundary pulse and sync loss level
  task automatic frame(input int p);
    @(posedge pclk);
    rx_frame_start[p] <= 1'b1;
    @(posedge pclk);
    rx_frame_start[p] <= 1'b0;
  endtask : frame
  task automatic loss(input int p, input logic v);
    @(posedge pclk);
    frame_sync_loss[p] <= v;
  endtask : loss
endmodule : rxsc_line_model
`default_nettype wire

// >>> verif/rxsc_top_sva.sv
// Port-level checks of the rx signaling bank: bus timing and data pass-through
`default_nettype none
module rxsc_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [7:0] rx_ts_valid,
  input wire logic [7:0][4:0] rx_ts_chan,
  input wire logic [7:0][7:0] rx_ts_data,
  input wire logic [7:0] rx_out_valid,
  input wire logic [7:0][4:0] rx_out_chan,
  input wire logic [7:0][7:0] rx_out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // First access cycle, the one that launches the reply
  logic acc1;
  assign acc1 = psel && penable && !pready;
  a_ready_next: assert property (acc1 |=> pready)
    else $error("no pready after access");
  a_ready_cause: assert property (pready |-> $past(acc1))
    else $error("pready without access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_misalign_err: assert property (acc1 && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("misaligned access not refused");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_data_hold: assert property (!pready |-> $stable(prdata))
    else $error("prdata moved between replies");
  a_out_valid: assert property (rx_out_valid == $past(rx_ts_valid))
    else $error("rx valid not one cycle late");
  // Port 0 channels outside 1..24 never take the milliwatt byte
  a_out_pass: assert property (
    rx_ts_valid[0] && (rx_ts_chan[0] == 5'd0 || rx_ts_chan[0] > 5'd24) |=>
    rx_out_data[0] == $past(rx_ts_data[0]) && rx_out_chan[0] == $past(rx_ts_chan[0]))
    else $error("rx data altered");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_rx: cover property (rx_out_valid[0]);
endmodule : rxsc_top_sva
bind rxsc_top rxsc_top_sva u_rxsc_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .rx_ts_valid(rx_ts_valid), .rx_ts_chan(rx_ts_chan),
  .rx_ts_data(rx_ts_data), .rx_out_valid(rx_out_valid), .rx_out_chan(rx_out_chan),
  .rx_out_data(rx_out_data));
`default_nettype wire

// >>> verif/rxsc_top_tb.sv
// Self-checking bench for the rx signaling, milliwatt and error counter bank
`default_nettype none
`include "rxsc_map.svh"
module rxsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0] p;
    logic [7:0] cfg;
    logic [4:0] ch;
    logic [3:0] s;
    logic [8:0] idx;
    logic [7:0] e;
  } rxsc_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, irq, rerr;
  logic [7:0] rx_frame_start, rx_ts_valid, rx_out_valid, sig_valid, frame_sync_loss;
  logic [7:0] lcv_event, pcv_event, fos_event, ebit_event;
  logic [7:0][4:0] rx_ts_chan, rx_out_chan, sig_chan;
  logic [7:0][7:0] rx_ts_data, rx_out_data;
  logic [7:0][3:0] sig_abcd;
  int errors = 0;
  int num_checks = 0;
  // Signaling captures: config, channel, nibble, register index, expected byte
  rxsc_row_t rows[12] = '{'{0, 2, 1, 4'ha, 9'h40, 8'ha0}, '{0, 2, 13, 4'h5, 9'h40, 8'ha5},
    '{0, 2, 12, 4'h3, 9'h4b, 8'h30}, '{0, 2, 24, 4'hc, 9'h4b, 8'h3c},
    '{0, 0, 2, 4'hb, 9'h41, 8'ha0}, '{0, 0, 14, 4'h4, 9'h41, 8'ha5},
    '{1, 1, 0, 4'h6, 9'h40, 8'h06}, '{1, 1, 1, 4'h9, 9'h41, 8'h90},
    '{1, 1, 16, 4'h4, 9'h41, 8'h94}, '{1, 1, 15, 4'h7, 9'h4f, 8'h70},
    '{1, 1, 30, 4'h1, 9'h4f, 8'h71}, '{7, 2, 5, 4'hf, 9'h44, 8'hf0}};
  always #5 pclk = ~pclk;
  rxsc_top u_rxsc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .rx_frame_start, .rx_ts_valid, .rx_ts_chan, .rx_ts_data,
    .rx_out_valid, .rx_out_chan, .rx_out_data, .sig_valid, .sig_chan, .sig_abcd,
    .frame_sync_loss, .lcv_event, .pcv_event, .fos_event, .ebit_event);
  rxsc_line_model u_rxsc_line_model (.pclk, .rx_frame_start, .rx_ts_valid, .rx_ts_chan,
    .rx_ts_data, .sig_valid, .sig_chan, .sig_abcd, .frame_sync_loss, .lcv_event,
    .pcv_event, .fos_event, .ebit_event);
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  function automatic logic [13:0] ad(input logic [2:0] p, input logic [8:0] i);
    ad = {p, i, 2'b00};
  endfunction : ad
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      conclude();
    end
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string s, input logic [2:0] p, input logic [8:0] i, input logic [7:0] e);
    apb(1'b0, ad(p, i), 8'h00);
    chk(s, {24'h0, e}, rdv);
  endtask : rd
  // Port 0 timeslot through the substitution stage
  task automatic tsc(input logic [4:0] c, input logic [7:0] d, input logic [7:0] e);
    u_rxsc_line_model.ts(0, c, d);
    #1;
    chk("rx data", {24'h0, e}, {24'h0, rx_out_data[0]});
  endtask : tsc
  // Hang guard, well over the run time of the test
  initial begin
    #500us;
    errors++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 9'h03c; i <= 9'h057; i++) begin
      if (i != 9'h03f) rd("reset", 3'd0, 9'(i), 8'h00);
    end
    rd("ebit hi reset", 3'd5, 9'h056, 8'h00);
    // Table of signaling captures, each read back at once
    foreach (rows[k]) begin
      apb(1'b1, ad(rows[k].p, `RXSC_IDX_CFG), rows[k].cfg);
      u_rxsc_line_model.sig(rows[k].p, rows[k].ch, rows[k].s);
      rd("sig", rows[k].p, rows[k].idx, rows[k].e);
    end
    // Store must hold while sync is lost
    u_rxsc_line_model.loss(0, 1'b1);
    u_rxsc_line_model.sig(0, 5'd1, 4'h0);
    rd("frozen", 3'd0, 9'h040, 8'ha5);
    u_rxsc_line_model.loss(0, 1'b0);
    // Counters, back-to-back events and a carry into the high byte
    u_rxsc_line_model.ev(0, 4'b1000, 3);
    u_rxsc_line_model.ev(0, 4'b0100, 1);
    u_rxsc_line_model.ev(0, 4'b0010, 2);
    u_rxsc_line_model.ev(0, 4'b0001, 1);
    u_rxsc_line_model.ev(1, 4'b0001, 2);
    u_rxsc_line_model.ev(2, 4'b1000, 256);
    rd("lcv hi", 3'd0, 9'h050, 8'h00);
    rd("lcv lo", 3'd0, 9'h051, 8'h03);
    rd("pcv lo", 3'd0, 9'h053, 8'h01);
    rd("fos lo", 3'd0, 9'h055, 8'h02);
    rd("ebit in t1", 3'd0, 9'h057, 8'h00);
    rd("ebit hi e1", 3'd1, 9'h056, 8'h00);
    rd("ebit lo e1", 3'd1, 9'h057, 8'h02);
    rd("lcv carry hi", 3'd2, 9'h050, 8'h01);
    rd("lcv carry lo", 3'd2, 9'h051, 8'h00);
    // Writes to counts ignored, bad addresses refused
    apb(1'b1, ad(0, 9'h051), 8'hff);
    rd("lcv after write", 3'd0, 9'h051, 8'h03);
    apb(1'b0, ad(0, 9'h1ff), 8'h00);
    chk("unmapped", 32'h1, {31'h0, rerr});
    apb(1'b0, ad(0, 9'h050) | 14'h1, 8'h00);
    chk("misaligned", 32'h1, {31'h0, rerr});
    // Milliwatt enables: channel 3 and channel 24
    apb(1'b1, ad(0, 9'h03c), 8'h04);
    apb(1'b1, ad(0, 9'h03e), 8'h80);
    rd("mw enable", 3'd0, 9'h03c, 8'h04);
    tsc(5'd3, 8'h55, `RXSC_MW_B0);
    tsc(5'd4, 8'h55, 8'h55);
    tsc(5'd25, 8'h3c, 8'h3c);
    u_rxsc_line_model.frame(0);
    tsc(5'd24, 8'h55, `RXSC_MW_B1);
    // Interrupt: masked, unmasked, then cleared by writing one
    rd("int status", 3'd0, `RXSC_IDX_INT_STAT, 8'h03);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, ad(0, `RXSC_IDX_INT_MASK), 8'h01);
    repeat (3) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, ad(0, `RXSC_IDX_INT_STAT), 8'h01);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd("int status left", 3'd0, `RXSC_IDX_INT_STAT, 8'h02);
    conclude();
  end
endmodule : rxsc_top_tb
`default_nettype wire
